// File: rtl/urd_regs.v
// register decode, register file and internal loopback of the uart
`timescale 1ns/100ps
`include "urd_defs.vh"

module urd_regs
(
    input  wire       REF_CLK,
    input  wire       RST_B,
    input  wire [2:0] ADDR,
    input  wire [7:0] WR_DATA,
    input  wire       WR_STB,
    input  wire       RD_STB,
    output reg  [7:0] RD_DATA,
    output reg        RD_VALID,
    input  wire [7:0] RX_HOLD_IN,
    input  wire [7:0] ISR_IN,
    input  wire [7:0] LSR_IN,
    input  wire [7:0] MSR_IN,
    input  wire [7:0] FIFO_LEVEL_IN,
    output reg        TX_LOAD,
    output reg  [7:0] TX_DATA,
    output reg        QCTL_LOAD,
    output reg        FIFO_TRIGGER_LEVEL_LOAD,
    output reg        ENHANCED_MODE_SELECT_LOAD,
    output reg  [7:0] CTL_DATA,
    output reg        RX_POP,
    output reg        ISR_READ,
    output reg        LSR_READ,
    output reg        MSR_READ,
    output reg  [7:0] DIV_LOW,
    output reg  [7:0] DIV_HIGH,
    output reg  [7:0] DIV_FRAC,
    output reg  [7:0] INT_ENABLE,
    output reg  [7:0] LINE_CTL,
    output reg  [7:0] MODEM_CTL,
    output reg  [7:0] MSR_CTL,
    output reg  [7:0] FEATURE_CTL,
    output reg  [7:0] ENH_FUNC,
    output reg  [7:0] RESUME_ONE,
    output reg  [7:0] RESUME_TWO,
    output reg  [7:0] PAUSE_ONE,
    output reg  [7:0] PAUSE_TWO,
    output reg        LOOPBACK,
    input  wire       TSR_SERIAL,
    input  wire       RX_PIN,
    output reg        RSR_SERIAL,
    output reg        TX_PIN,
    output reg        RTS_PIN_B,
    output reg        DTR_PIN_B,
    input  wire       CTS_PIN_B,
    input  wire       DSR_PIN_B,
    input  wire       CD_PIN_B,
    input  wire       RI_PIN_B,
    output reg        CTS_CORE_B,
    output reg        DSR_CORE_B,
    output reg        CD_CORE_B,
    output reg        RI_CORE_B
);

    // address decode shared by the read and write paths
    function [4:0] dec_sel;
        input [2:0] a;
        input       rd;
        input [7:0] lc;
        input       enh4;
        input       sel7;
        input       divz;
        reg         bank;
        reg         dv;
        begin
            bank = (lc == `URD_LC_ENH_KEY);
            dv   = lc[`URD_DIV_BIT];
            dec_sel = `URD_T_NONE;
            case (a)
                `URD_A_0:
                begin
                    if (bank)
                        dec_sel = `URD_T_FCTRIG;
                    else if (dv)
                        dec_sel = (rd && divz) ? `URD_T_REV : `URD_T_DLL;
                    else
                        dec_sel = `URD_T_HOLD;
                end
                `URD_A_1:
                begin
                    if (bank)
                        dec_sel = `URD_T_FEATURE_CONTROL;
                    else if (dv)
                        dec_sel = (rd && divz) ? `URD_T_ID : `URD_T_DLM;
                    else
                        dec_sel = `URD_T_IER;
                end
                `URD_A_2:
                begin
                    if (bank)
                        dec_sel = `URD_T_EFR;
                    else if (dv && enh4)
                        dec_sel = `URD_T_DLD;
                    else
                        dec_sel = `URD_T_ISRQ;
                end
                `URD_A_3:
                    dec_sel = `URD_T_LCR;
                `URD_A_4:
                    dec_sel = bank ? `URD_T_XON1 : `URD_T_MCR;
                `URD_A_5:
                begin
                    if (bank)
                        dec_sel = `URD_T_XON2;
                    else
                        dec_sel = rd ? `URD_T_LSR : `URD_T_NONE;
                end
                `URD_A_6:
                begin
                    if (bank)
                        dec_sel = `URD_T_XOFF1;
                    else if (rd || enh4)
                        dec_sel = `URD_T_MSR;
                    else
                        dec_sel = `URD_T_NONE;
                end
                `URD_A_7:
                begin
                    if (bank)
                        dec_sel = `URD_T_XOFF2;
                    else
                        dec_sel = sel7 ? `URD_T_EMFC : `URD_T_SPR;
                end
                default:
                    dec_sel = `URD_T_NONE;
            endcase
        end
    endfunction

    reg  [7:0] spr_q;
    reg  [4:0] s1_q;
    reg  [4:0] s2_q;
    reg  [4:0] s3_q;
    reg  [4:0] filt_q;
    wire [4:0] pin_raw;
    wire       divz;
    wire       loop_on;
    wire [4:0] wsel;
    wire [4:0] rsel;
    reg  [7:0] rd_d;

    assign divz    = (DIV_LOW == 8'h00) && (DIV_HIGH == 8'h00);
    assign loop_on = MODEM_CTL[`URD_LOOP_BIT];
    assign wsel    = dec_sel(ADDR, 1'b0, LINE_CTL, ENH_FUNC[`URD_ENH_BIT],
                             FEATURE_CTL[`URD_SEL7_BIT], divz);
    assign rsel    = dec_sel(ADDR, 1'b1, LINE_CTL, ENH_FUNC[`URD_ENH_BIT],
                             FEATURE_CTL[`URD_SEL7_BIT], divz);
    assign pin_raw = {RI_PIN_B, CD_PIN_B, DSR_PIN_B, CTS_PIN_B, RX_PIN};

    // three-stage pin synchroniser; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            always @(posedge REF_CLK or negedge RST_B)
            begin
                if (!RST_B)
                begin
                    s1_q[gi]   <= 1'b1;
                    s2_q[gi]   <= 1'b1;
                    s3_q[gi]   <= 1'b1;
                    filt_q[gi] <= 1'b1;
                end
                else
                begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi])
                        filt_q[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate

    // register file writes; unmapped or read-only targets store nothing
    always @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            DIV_LOW     <= `URD_RST_BYTE;
            DIV_HIGH    <= `URD_RST_BYTE;
            DIV_FRAC    <= `URD_RST_BYTE;
            INT_ENABLE  <= `URD_RST_BYTE;
            LINE_CTL    <= `URD_RST_LCR;
            MODEM_CTL   <= `URD_RST_MCR;
            MSR_CTL     <= `URD_RST_BYTE;
            FEATURE_CTL <= `URD_RST_BYTE;
            ENH_FUNC    <= `URD_RST_BYTE;
            RESUME_ONE  <= `URD_RST_BYTE;
            RESUME_TWO  <= `URD_RST_BYTE;
            PAUSE_ONE   <= `URD_RST_BYTE;
            PAUSE_TWO   <= `URD_RST_BYTE;
            spr_q       <= `URD_RST_BYTE;
        end
        else if (WR_STB)
        begin
            case (wsel)
                `URD_T_DLL:   DIV_LOW     <= WR_DATA;
                `URD_T_DLM:   DIV_HIGH    <= WR_DATA;
                `URD_T_DLD:   DIV_FRAC    <= WR_DATA;
                `URD_T_IER:   INT_ENABLE  <= WR_DATA;
                `URD_T_LCR:   LINE_CTL    <= WR_DATA;
                `URD_T_MCR:   MODEM_CTL   <= WR_DATA;
                `URD_T_MSR:   MSR_CTL     <= WR_DATA;
                `URD_T_SPR:   spr_q       <= WR_DATA;
                `URD_T_FEATURE_CONTROL:  FEATURE_CTL <= WR_DATA;
                `URD_T_EFR:   ENH_FUNC    <= WR_DATA;
                `URD_T_XON1:  RESUME_ONE  <= WR_DATA;
                `URD_T_XON2:  RESUME_TWO  <= WR_DATA;
                `URD_T_XOFF1: PAUSE_ONE   <= WR_DATA;
                `URD_T_XOFF2: PAUSE_TWO   <= WR_DATA;
                default:      spr_q       <= spr_q;
            endcase
        end
    end

    // one-cycle load strobes toward the uart core for write-only targets
    always @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            TX_LOAD   <= 1'b0;
            QCTL_LOAD <= 1'b0;
            FIFO_TRIGGER_LEVEL_LOAD <= 1'b0;
            ENHANCED_MODE_SELECT_LOAD <= 1'b0;
            TX_DATA   <= `URD_RST_BYTE;
            CTL_DATA  <= `URD_RST_BYTE;
        end
        else
        begin
            TX_LOAD   <= WR_STB && (wsel == `URD_T_HOLD);
            QCTL_LOAD <= WR_STB && (wsel == `URD_T_ISRQ);
            FIFO_TRIGGER_LEVEL_LOAD <= WR_STB && (wsel == `URD_T_FCTRIG);
            ENHANCED_MODE_SELECT_LOAD <= WR_STB && (wsel == `URD_T_EMFC);
            if (WR_STB)
            begin
                TX_DATA  <= WR_DATA;
                CTL_DATA <= WR_DATA;
            end
        end
    end

    // read mux; trigger and mode select targets read the fifo level, unmatched selects read as zero
    always @*
    begin
        case (rsel)
            `URD_T_HOLD:   rd_d = RX_HOLD_IN;
            `URD_T_DLL:    rd_d = DIV_LOW;
            `URD_T_DLM:    rd_d = DIV_HIGH;
            `URD_T_DLD:    rd_d = DIV_FRAC;
            `URD_T_REV:    rd_d = `URD_REV_CODE;
            `URD_T_ID:     rd_d = `URD_ID_CODE;
            `URD_T_IER:    rd_d = INT_ENABLE;
            `URD_T_ISRQ:   rd_d = ISR_IN;
            `URD_T_LCR:    rd_d = LINE_CTL;
            `URD_T_MCR:    rd_d = MODEM_CTL;
            `URD_T_LSR:    rd_d = LSR_IN;
            `URD_T_MSR:    rd_d = MSR_IN;
            `URD_T_SPR:    rd_d = spr_q;
            `URD_T_EMFC:   rd_d = FIFO_LEVEL_IN;
            `URD_T_FCTRIG: rd_d = FIFO_LEVEL_IN;
            `URD_T_FEATURE_CONTROL:   rd_d = FEATURE_CTL;
            `URD_T_EFR:    rd_d = ENH_FUNC;
            `URD_T_XON1:   rd_d = RESUME_ONE;
            `URD_T_XON2:   rd_d = RESUME_TWO;
            `URD_T_XOFF1:  rd_d = PAUSE_ONE;
            `URD_T_XOFF2:  rd_d = PAUSE_TWO;
            default:       rd_d = 8'h00;
        endcase
    end

    // read data and read side-effect strobes, one cycle after the strobe
    always @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            RD_DATA  <= `URD_RST_BYTE;
            RD_VALID <= 1'b0;
            RX_POP   <= 1'b0;
            ISR_READ <= 1'b0;
            LSR_READ <= 1'b0;
            MSR_READ <= 1'b0;
        end
        else
        begin
            RD_VALID <= RD_STB;
            if (RD_STB)
                RD_DATA <= rd_d;
            RX_POP   <= RD_STB && (rsel == `URD_T_HOLD);
            ISR_READ <= RD_STB && (rsel == `URD_T_ISRQ);
            LSR_READ <= RD_STB && (rsel == `URD_T_LSR);
            MSR_READ <= RD_STB && (rsel == `URD_T_MSR);
        end
    end

    // loopback steering; registered so every pin comes from a flop,
    // at the cost of one clock of latency on the serial paths
    always @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            LOOPBACK   <= 1'b0;
            TX_PIN     <= 1'b1;
            RSR_SERIAL <= 1'b1;
            RTS_PIN_B  <= 1'b1;
            DTR_PIN_B  <= 1'b1;
            CTS_CORE_B <= 1'b1;
            DSR_CORE_B <= 1'b1;
            CD_CORE_B  <= 1'b1;
            RI_CORE_B  <= 1'b1;
        end
        else if (loop_on)
        begin
            LOOPBACK   <= 1'b1;
            TX_PIN     <= 1'b1;
            RSR_SERIAL <= TSR_SERIAL;
            RTS_PIN_B  <= 1'b1;
            DTR_PIN_B  <= 1'b1;
            // modem inputs come from modem control outputs, pins ignored
            CTS_CORE_B <= ~MODEM_CTL[`URD_RTS_BIT];
            DSR_CORE_B <= ~MODEM_CTL[`URD_DTR_BIT];
            CD_CORE_B  <= ~MODEM_CTL[`URD_OP2_BIT];
            RI_CORE_B  <= ~MODEM_CTL[`URD_OP1_BIT];
        end
        else
        begin
            LOOPBACK   <= 1'b0;
            TX_PIN     <= TSR_SERIAL;
            RSR_SERIAL <= filt_q[0];
            RTS_PIN_B  <= ~MODEM_CTL[`URD_RTS_BIT];
            DTR_PIN_B  <= ~MODEM_CTL[`URD_DTR_BIT];
            CTS_CORE_B <= filt_q[1];
            DSR_CORE_B <= filt_q[2];
            CD_CORE_B  <= filt_q[3];
            RI_CORE_B  <= filt_q[4];
        end
    end

endmodule // urd_regs

// File: pkg/urd_defs.vh
// constants for the uart register decode and loopback block
`ifndef URD_DEFS_VH
`define URD_DEFS_VH

// register offsets on the 3-bit address
`define URD_A_0          3'h0
`define URD_A_1          3'h1
`define URD_A_2          3'h2
`define URD_A_3          3'h3
`define URD_A_4          3'h4
`define URD_A_5          3'h5
`define URD_A_6          3'h6
`define URD_A_7          3'h7

// line control value that opens the enhanced bank
`define URD_LC_ENH_KEY   8'hbf

// field positions
`define URD_DIV_BIT      7
`define URD_ENH_BIT      4
`define URD_SEL7_BIT     6
`define URD_LOOP_BIT     4
`define URD_OP2_BIT      3
`define URD_OP1_BIT      2
`define URD_RTS_BIT      1
`define URD_DTR_BIT      0

// decoded targets, read and write meaning per direction
`define URD_T_NONE       5'h00
`define URD_T_HOLD       5'h01
`define URD_T_DLL        5'h02
`define URD_T_DLM        5'h03
`define URD_T_DLD        5'h04
`define URD_T_REV        5'h05
`define URD_T_ID         5'h06
`define URD_T_IER        5'h07
`define URD_T_ISRQ       5'h08
`define URD_T_LCR        5'h09
`define URD_T_MCR        5'h0a
`define URD_T_LSR        5'h0b
`define URD_T_MSR        5'h0c
`define URD_T_SPR        5'h0d
`define URD_T_EMFC       5'h0e
`define URD_T_FCTRIG     5'h0f
`define URD_T_FEATURE_CONTROL       5'h10
`define URD_T_EFR        5'h11
`define URD_T_XON1       5'h12
`define URD_T_XON2       5'h13
`define URD_T_XOFF1      5'h14
`define URD_T_XOFF2      5'h15

// reset values
`define URD_RST_BYTE     8'h00
`define URD_RST_LCR      8'h00
`define URD_RST_MCR      8'h00

// identity codes, values are arbitrary
`define URD_REV_CODE     8'h5a
`define URD_ID_CODE      8'ha5

`endif

// File: tb/urd_props.sv
// concurrent checks on the ports of the register decode and loopback block
`timescale 1ns/100ps
`include "urd_defs.vh"
module urd_props
(
    input wire       REF_CLK,
    input wire       RST_B,
    input wire [2:0] ADDR,
    input wire [7:0] WR_DATA,
    input wire       WR_STB,
    input wire       RD_STB,
    input wire [7:0] RD_DATA,
    input wire       RD_VALID,
    input wire [7:0] RX_HOLD_IN,
    input wire       TX_LOAD,
    input wire [7:0] TX_DATA,
    input wire       RX_POP,
    input wire [7:0] DIV_LOW,
    input wire [7:0] DIV_HIGH,
    input wire [7:0] LINE_CTL,
    input wire [7:0] MODEM_CTL,
    input wire [7:0] ENH_FUNC,
    input wire       LOOPBACK,
    input wire       TSR_SERIAL,
    input wire       RSR_SERIAL,
    input wire       TX_PIN,
    input wire       RTS_PIN_B,
    input wire       DTR_PIN_B,
    input wire       CTS_CORE_B,
    input wire       DSR_CORE_B
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // decode sees the registers as they stood before the taking edge
    wire std_bank = (LINE_CTL != `URD_LC_ENH_KEY);

    AST_THR_LOAD: assert property (WR_STB && ADDR == 3'h0 && !LINE_CTL[7]
        |=> TX_LOAD && TX_DATA == $past(WR_DATA)) else $error("holding write lost");
    AST_RHR_READ: assert property (RD_STB && ADDR == 3'h0 && !LINE_CTL[7]
        |=> RD_VALID && RX_POP && RD_DATA == $past(RX_HOLD_IN)) else $error("rx read wrong");
    AST_ID_READ: assert property (RD_STB && ADDR == 3'h1 && LINE_CTL[7] && std_bank
        && DIV_LOW == 8'h00 && DIV_HIGH == 8'h00 |=> RD_DATA == `URD_ID_CODE)
        else $error("id code not returned");
    AST_LSR_RO: assert property (WR_STB && ADDR == 3'h5 && std_bank
        |=> $stable(LINE_CTL) && $stable(MODEM_CTL) && !TX_LOAD) else $error("status write acted");
    AST_EFR_WRITE: assert property (WR_STB && ADDR == 3'h2 && !std_bank
        |=> ENH_FUNC == $past(WR_DATA)) else $error("enhanced function write lost");
    AST_LOOP_ENTER: assert property (WR_STB && ADDR == 3'h4 && std_bank
        |=> ##1 LOOPBACK == $past(WR_DATA[4], 2)) else $error("loopback does not follow bit 4");
    AST_TX_MARK: assert property (LOOPBACK |-> TX_PIN && RTS_PIN_B && DTR_PIN_B)
        else $error("pins not idle in loopback");
    AST_LOOP_SERIAL: assert property (LOOPBACK && $past(LOOPBACK)
        |-> RSR_SERIAL == $past(TSR_SERIAL)) else $error("serial loop broken");
    AST_LOOP_MODEM: assert property (LOOPBACK && $past(LOOPBACK)
        |-> CTS_CORE_B == !$past(MODEM_CTL[1]) && DSR_CORE_B == !$past(MODEM_CTL[0]))
        else $error("modem inputs not isolated");
endmodule // urd_props

bind urd_regs urd_props PROPS (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .RX_HOLD_IN(RX_HOLD_IN), .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA), .RX_POP(RX_POP),
    .DIV_LOW(DIV_LOW), .DIV_HIGH(DIV_HIGH), .LINE_CTL(LINE_CTL), .MODEM_CTL(MODEM_CTL),
    .ENH_FUNC(ENH_FUNC), .LOOPBACK(LOOPBACK), .TSR_SERIAL(TSR_SERIAL),
    .RSR_SERIAL(RSR_SERIAL), .TX_PIN(TX_PIN), .RTS_PIN_B(RTS_PIN_B), .DTR_PIN_B(DTR_PIN_B),
    .CTS_CORE_B(CTS_CORE_B), .DSR_CORE_B(DSR_CORE_B));

// File: tb/urd_core_model.sv
// far side model: uart core status sources and transmit shifter activity
`timescale 1ns/100ps
module urd_core_model
(
    input  wire       clk,
    input  wire       rst_b,
    output wire [7:0] rx_hold,
    output wire [7:0] isr_val,
    output wire [7:0] lsr_val,
    output wire [7:0] msr_val,
    output wire [7:0] lvl_val,
    output wire       tsr_out,
    output wire       rx_line
);
    reg [7:0] pat_q;
    // distinct bytes so a wrong decode reads a wrong value
    assign rx_hold = 8'h3c;
    assign isr_val = 8'hc1;
    assign lsr_val = 8'h60;
    assign msr_val = 8'hb0;
    assign lvl_val = 8'h11;
    // shifter output keeps changing so a stuck loop path shows
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            pat_q <= 8'hb4;
        else
            pat_q <= {pat_q[6:0], pat_q[7]};
    end
    assign tsr_out = pat_q[7];
    assign rx_line = 1'b1; // receive line held at mark
endmodule // urd_core_model

// File: tb/test_uart_register_decode_loopback.sv
// self-checking bench for the register decode and loopback block
`timescale 1ns/100ps
`include "urd_defs.vh"
module test_uart_register_decode_loopback;
    logic       REF_CLK = 0, RST_B = 0, WR_STB = 0, RD_STB = 0, RX_PIN, TSR_SERIAL;
    logic [2:0] ADDR = 0;
    logic [7:0] WR_DATA = 0, RD_DATA, TX_DATA, CTL_DATA, RX_HOLD_IN, ISR_IN, LSR_IN, MSR_IN;
    logic [7:0] FIFO_LEVEL_IN, DIV_LOW, DIV_HIGH, DIV_FRAC, INT_ENABLE, LINE_CTL, MODEM_CTL;
    logic [7:0] MSR_CTL, FEATURE_CTL, ENH_FUNC, RESUME_ONE, RESUME_TWO, PAUSE_ONE, PAUSE_TWO;
    logic       RD_VALID, TX_LOAD, QCTL_LOAD, FIFO_TRIGGER_LEVEL_LOAD, ENHANCED_MODE_SELECT_LOAD, RX_POP, ISR_READ, LSR_READ;
    logic       MSR_READ, LOOPBACK, RSR_SERIAL, TX_PIN, RTS_PIN_B, DTR_PIN_B;
    logic       CTS_PIN_B = 1, DSR_PIN_B = 1, CD_PIN_B = 1, RI_PIN_B = 1;
    logic       CTS_CORE_B, DSR_CORE_B, CD_CORE_B, RI_CORE_B, tsr_bit;
    int         errors = 0, compares = 0;

    always #4 REF_CLK = ~REF_CLK;

    urd_regs DUT (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
        .RX_HOLD_IN(RX_HOLD_IN), .ISR_IN(ISR_IN), .LSR_IN(LSR_IN), .MSR_IN(MSR_IN),
        .FIFO_LEVEL_IN(FIFO_LEVEL_IN), .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA),
        .QCTL_LOAD(QCTL_LOAD), .FIFO_TRIGGER_LEVEL_LOAD(FIFO_TRIGGER_LEVEL_LOAD), .ENHANCED_MODE_SELECT_LOAD(ENHANCED_MODE_SELECT_LOAD),
        .CTL_DATA(CTL_DATA), .RX_POP(RX_POP), .ISR_READ(ISR_READ), .LSR_READ(LSR_READ),
        .MSR_READ(MSR_READ), .DIV_LOW(DIV_LOW), .DIV_HIGH(DIV_HIGH), .DIV_FRAC(DIV_FRAC),
        .INT_ENABLE(INT_ENABLE), .LINE_CTL(LINE_CTL), .MODEM_CTL(MODEM_CTL),
        .MSR_CTL(MSR_CTL), .FEATURE_CTL(FEATURE_CTL), .ENH_FUNC(ENH_FUNC),
        .RESUME_ONE(RESUME_ONE), .RESUME_TWO(RESUME_TWO), .PAUSE_ONE(PAUSE_ONE),
        .PAUSE_TWO(PAUSE_TWO), .LOOPBACK(LOOPBACK), .TSR_SERIAL(TSR_SERIAL),
        .RX_PIN(RX_PIN), .RSR_SERIAL(RSR_SERIAL), .TX_PIN(TX_PIN), .RTS_PIN_B(RTS_PIN_B),
        .DTR_PIN_B(DTR_PIN_B), .CTS_PIN_B(CTS_PIN_B), .DSR_PIN_B(DSR_PIN_B),
        .CD_PIN_B(CD_PIN_B), .RI_PIN_B(RI_PIN_B), .CTS_CORE_B(CTS_CORE_B),
        .DSR_CORE_B(DSR_CORE_B), .CD_CORE_B(CD_CORE_B), .RI_CORE_B(RI_CORE_B));
    urd_core_model MODEL (.clk(REF_CLK), .rst_b(RST_B), .rx_hold(RX_HOLD_IN), .isr_val(ISR_IN),
        .lsr_val(LSR_IN), .msr_val(MSR_IN), .lvl_val(FIFO_LEVEL_IN), .tsr_out(TSR_SERIAL),
        .rx_line(RX_PIN));

    task results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task pul(input string n, input logic p);
        chk(n, 8'h01, {7'h0, p});
    endtask

    // one write strobe; returns where the effect of the taking edge is visible
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge REF_CLK);
        ADDR = a;
        WR_DATA = d;
        WR_STB = 1;
        @(negedge REF_CLK);
        WR_STB = 0;
    endtask

    // the valid flag stands only one cycle, so it is looked at right then
    task rd(input logic [2:0] a, input logic [7:0] e, input string n);
        @(negedge REF_CLK);
        ADDR = a;
        RD_STB = 1;
        @(negedge REF_CLK);
        RD_STB = 0;
        pul("read valid", RD_VALID);
        chk(n, e, RD_DATA);
    endtask

    // a hang is cut short and counted as a mismatch
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        errors++;
        $display("[FAIL] watchdog expected done seen hang");
        results;
    end

    initial
    begin
        repeat (5) @(negedge REF_CLK);
        RST_B = 1;
        rd(3'h3, 8'h00, "line_control");
        rd(3'h4, 8'h00, "modem_control");
        wr(3'h3, 8'h03);
        rd(3'h3, 8'h03, "line_control");
        chk("line_control port", 8'h03, LINE_CTL);
        wr(3'h0, 8'h41);
        pul("tx load", TX_LOAD);
        chk("tx data", 8'h41, TX_DATA);
        rd(3'h0, RX_HOLD_IN, "receive_holding");
        pul("rx pop", RX_POP);
        wr(3'h1, 8'h0f);
        rd(3'h1, 8'h0f, "interrupt_enable");
        chk("interrupt_enable port", 8'h0f, INT_ENABLE);
        rd(3'h2, ISR_IN, "interrupt_status");
        pul("status read strobe", ISR_READ);
        wr(3'h2, 8'hc7);
        pul("queue load", QCTL_LOAD);
        chk("ctl data", 8'hc7, CTL_DATA);
        rd(3'h5, LSR_IN, "line_status");
        pul("line status read strobe", LSR_READ);
        wr(3'h5, 8'hff);
        rd(3'h3, 8'h03, "line_control kept");
        rd(3'h6, MSR_IN, "modem_status");
        pul("modem status read strobe", MSR_READ);
        wr(3'h6, 8'hf0);
        chk("status ctl kept", 8'h00, MSR_CTL);
        wr(3'h7, 8'h5c);
        rd(3'h7, 8'h5c, "scratch");
        // divisor bank while both divisor bytes are still zero
        wr(3'h3, 8'h80);
        rd(3'h0, `URD_REV_CODE, "revision");
        rd(3'h1, `URD_ID_CODE, "identification");
        rd(3'h2, ISR_IN, "status in divisor bank");
        wr(3'h0, 8'h12);
        wr(3'h1, 8'h34);
        rd(3'h0, 8'h12, "divisor_low");
        rd(3'h1, 8'h34, "divisor_high");
        chk("divisor_low port", 8'h12, DIV_LOW);
        chk("divisor_high port", 8'h34, DIV_HIGH);
        // enhanced bank
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        rd(3'h2, 8'h10, "enhanced_function");
        wr(3'h1, 8'h40);
        rd(3'h1, 8'h40, "feature_control");
        chk("feature_control port", 8'h40, FEATURE_CTL);
        chk("enhanced_function port", 8'h10, ENH_FUNC);
        rd(3'h0, FIFO_LEVEL_IN, "level count");
        wr(3'h0, 8'h2d);
        pul("trigger load", FIFO_TRIGGER_LEVEL_LOAD);
        for (int i = 4; i < 8; i++)
            wr(i[2:0], 8'ha0 + i[7:0]);
        for (int i = 4; i < 8; i++)
            rd(i[2:0], 8'ha0 + i[7:0], "flow char");
        chk("resume one port", 8'ha4, RESUME_ONE);
        chk("resume two port", 8'ha5, RESUME_TWO);
        chk("pause one port", 8'ha6, PAUSE_ONE);
        chk("pause two port", 8'ha7, PAUSE_TWO);
        chk("modem ctl untouched", 8'h00, MODEM_CTL);
        // fraction needs the divisor bit and the enhanced bit
        wr(3'h3, 8'h80);
        wr(3'h2, 8'h09);
        rd(3'h2, 8'h09, "divisor_fraction");
        chk("divisor_fraction port", 8'h09, DIV_FRAC);
        wr(3'h3, 8'h00);
        wr(3'h6, 8'h30);
        chk("status ctl", 8'h30, MSR_CTL);
        wr(3'h7, 8'h55);
        pul("mode select load", ENHANCED_MODE_SELECT_LOAD);
        rd(3'h7, FIFO_LEVEL_IN, "level at seven");
        // loopback: pins idle, modem inputs taken from modem control
        wr(3'h4, 8'h13);
        @(negedge REF_CLK);
        pul("loopback", LOOPBACK);
        chk("pins", 8'h07, {5'h0, TX_PIN, RTS_PIN_B, DTR_PIN_B});
        {CTS_PIN_B, DSR_PIN_B, CD_PIN_B, RI_PIN_B} = 4'h0;
        repeat (6) @(negedge REF_CLK);
        chk("core modem", 8'h03, {4'h0, CTS_CORE_B, DSR_CORE_B, CD_CORE_B, RI_CORE_B});
        // the shifter bit seen off the edge must reach the receive side at the next edge
        for (int k = 0; k < 8; k++)
        begin
            tsr_bit = TSR_SERIAL;
            @(negedge REF_CLK);
            chk("loop serial", {7'h0, tsr_bit}, {7'h0, RSR_SERIAL});
        end
        rd(3'h5, LSR_IN, "status in loopback");
        wr(3'h4, 8'h03);
        repeat (6) @(negedge REF_CLK);
        chk("pins", 8'h00, {5'h0, LOOPBACK, RTS_PIN_B, DTR_PIN_B});
        chk("core modem", 8'h00, {4'h0, CTS_CORE_B, DSR_CORE_B, CD_CORE_B, RI_CORE_B});
        // out of loopback the shifter drives the pin and the receive side hears the pin
        for (int k = 0; k < 8; k++)
        begin
            tsr_bit = TSR_SERIAL;
            @(negedge REF_CLK);
            chk("tx pin", {7'h0, tsr_bit}, {7'h0, TX_PIN});
        end
        pul("rx path", RSR_SERIAL);
        // second reset in mid-run: registers and pins return to idle
        RST_B = 0;
        repeat (2) @(negedge REF_CLK);
        RST_B = 1;
        chk("reset regs", 8'h00, MODEM_CTL | LINE_CTL | DIV_LOW | ENH_FUNC);
        pul("reset tx pin", TX_PIN);
        chk("reset loopback", 8'h00, {7'h0, LOOPBACK});
        rd(3'h3, 8'h00, "line_control after reset");
        results;
    end
endmodule // test_uart_register_decode_loopback
